// [ccb_consts.vh]
// constants for the coprocessor conditional branch unit
// assumes inclusion by bare name from the design files
`ifndef CCB_CONSTS_VH
`define CCB_CONSTS_VH

// instruction field positions
`define CCB_OP_HI        31
`define CCB_OP_LO        26
`define CCB_SUB_HI       25
`define CCB_SUB_LO       21
`define CCB_RS_HI        25
`define CCB_RS_LO        21
`define CCB_RT_HI        20
`define CCB_RT_LO        16
`define CCB_SEL_HI       20
`define CCB_SEL_LO       18
`define CCB_ND_BIT       17
`define CCB_TF_BIT       16
`define CCB_OFS_HI       15
`define CCB_OFS_LO       0
`define CCB_OFS_SIGN     15

// encodings
`define CCB_OP_COPROCESSOR_TWO      6'h12
`define CCB_SUB_BC       5'h08
`define CCB_OP_BEQ       6'h04
`define CCB_ZERO_REG     5'h00
`define CCB_SHIFT        2
`define CCB_DS_STEP      32'h0000_0004

// interrupt status bit positions
`define CCB_EV_CPU       0
`define CCB_EV_RI        1
`define CCB_EV_TAKEN     2
`define CCB_EV_SQUASH    3
`define CCB_EV_N         4

// apb register byte offsets
`define CCB_REG_CTRL     12'h000
`define CCB_REG_STAT     12'h004
`define CCB_REG_IRQ_ST   12'h008
`define CCB_REG_IRQ_EN   12'h00C
`define CCB_REG_IRQ_CLR  12'h010
`define CCB_REG_CNT      12'h014

// control register bits
`define CCB_CTRL_CU2     0
`define CCB_CTRL_PRES    1
`define CCB_CTRL_RESET   32'h0000_0002

`endif

// [ccb_decode.v]
// instruction field decode for the branch unit
// assumes a registered instruction word on the core clock
`default_nettype none
`include "ccb_consts.vh"

module ccb_decode #(
  parameter XLEN = 32
) (
  input  wire [31:0]     instr_i,
  output wire            is_coprocessor_two_br_o,
  output wire            is_beq_o,
  output wire            polarity_bit_o,
  output wire            nullify_delay_slot_bit_o,
  output wire [2:0]      condition_select_field_o,
  output wire [4:0]      rs_idx_o,
  output wire [4:0]      rt_idx_o,
  output wire [XLEN-1:0] displacement_o
);

  wire [17:0] ofs_shifted;

  // coprocessor branch group: major and sub opcode
  assign is_coprocessor_two_br_o = (instr_i[`CCB_OP_HI:`CCB_OP_LO] == `CCB_OP_COPROCESSOR_TWO) &&
                        (instr_i[`CCB_SUB_HI:`CCB_SUB_LO] == `CCB_SUB_BC);
  assign is_beq_o     = (instr_i[`CCB_OP_HI:`CCB_OP_LO] == `CCB_OP_BEQ);

  // tf and nd bits; selector 0 for the short form
  assign polarity_bit_o           = instr_i[`CCB_TF_BIT];
  assign nullify_delay_slot_bit_o = instr_i[`CCB_ND_BIT];
  assign condition_select_field_o = instr_i[`CCB_SEL_HI:`CCB_SEL_LO];
  assign rs_idx_o = instr_i[`CCB_RS_HI:`CCB_RS_LO];
  assign rt_idx_o = instr_i[`CCB_RT_HI:`CCB_RT_LO];

  // offset shifted left two, 18-bit result sign-extended
  assign ofs_shifted    = {instr_i[`CCB_OFS_HI:`CCB_OFS_LO], 2'b00};
  assign displacement_o = {{(XLEN-18){ofs_shifted[17]}}, ofs_shifted};

endmodule // ccb_decode

`default_nettype wire

// [ccb_apb_regs.v]
// apb slave holding control, status and interrupt registers
// assumes a single-clock apb master on the core clock
`default_nettype none
`include "ccb_consts.vh"

module ccb_apb_regs (
  input  wire                 core_clk_i,
  input  wire                 rst_i,
  input  wire                 ce_i,
  input  wire                 psel_i,
  input  wire                 penable_i,
  input  wire                 pwrite_i,
  input  wire [11:0]          paddr_i,
  input  wire [31:0]          pwdata_i,
  input  wire [`CCB_EV_N-1:0] event_i,
  input  wire [31:0]          status_i,
  input  wire [31:0]          count_i,
  output reg  [31:0]          prdata_o,
  output reg                  pready_o,
  output reg                  pslverr_o,
  output reg  [31:0]          ctrl_o,
  output reg                  irq_o
);

  reg  [`CCB_EV_N-1:0] irq_st_reg;
  reg  [`CCB_EV_N-1:0] irq_en_reg;
  reg  [`CCB_EV_N-1:0] clr_pulse;
  reg  [31:0]          rd_mux;
  reg                  addr_ok;
  wire                 acc;
  wire                 wr_done;

  // one wait state per access: pready answers in the second access cycle
  assign acc = psel_i && penable_i && !pready_o;
  // writes land only at the edge where the master sees pready high
  assign wr_done = psel_i && penable_i && pready_o && pwrite_i;

  // read decode, unmapped offsets answer with an error
  always @* begin
    rd_mux  = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr_i)
      `CCB_REG_CTRL:    rd_mux = ctrl_o;
      `CCB_REG_STAT:    rd_mux = status_i;
      `CCB_REG_IRQ_ST:  rd_mux = {{(32-`CCB_EV_N){1'b0}}, irq_st_reg};
      `CCB_REG_IRQ_EN:  rd_mux = {{(32-`CCB_EV_N){1'b0}}, irq_en_reg};
      `CCB_REG_IRQ_CLR: rd_mux = 32'h0000_0000; // write-only
      `CCB_REG_CNT:     rd_mux = count_i;
      default:          addr_ok = 1'b0;
    endcase
    clr_pulse = (wr_done && paddr_i == `CCB_REG_IRQ_CLR) ?
                pwdata_i[`CCB_EV_N-1:0] : {`CCB_EV_N{1'b0}};
  end

  // register writes and sticky status; a set beats a same-cycle clear
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      prdata_o   <= 32'h0000_0000;
      pready_o   <= 1'b0;
      pslverr_o  <= 1'b0;
      ctrl_o     <= `CCB_CTRL_RESET;
      irq_en_reg <= {`CCB_EV_N{1'b0}};
      irq_st_reg <= {`CCB_EV_N{1'b0}};
      irq_o      <= 1'b0;
    end else if (ce_i) begin
      pready_o  <= acc;
      pslverr_o <= acc && !addr_ok;
      prdata_o  <= (acc && !pwrite_i) ? rd_mux : 32'h0000_0000;
      if (wr_done && paddr_i == `CCB_REG_CTRL)
        ctrl_o <= pwdata_i;
      if (wr_done && paddr_i == `CCB_REG_IRQ_EN)
        irq_en_reg <= pwdata_i[`CCB_EV_N-1:0];
      irq_st_reg <= (irq_st_reg & ~clr_pulse) | event_i;
      irq_o      <= |(((irq_st_reg & ~clr_pulse) | event_i) & irq_en_reg);
    end
  end

endmodule // ccb_apb_regs

`default_nettype wire

// [ccb_branch_unit.v]
// coprocessor conditional branch and branch-if-equal resolution unit
// assumes instructions are presented one per issue step with their pc
// and register operands; condition bits come from coprocessor two
//
// Contract
// - the displacement is the 16-bit offset shifted left two, sign-extended, added to the delay-slot pc.
// - coprocessor-false branches are taken when the selected condition bit is 0.
// - coprocessor-true branches are taken when the selected condition bit is 1.
// - condition and target are formed in the branch step and the pc moves only after the delay slot.
// - a likely branch that is not taken squashes its delay slot; a taken one lets it run.
// - coprocessor branches decode from opcode 010010 and sub-opcode 01000 with tf and nd bits.
// - the condition-select field chooses the tested bit, zero for the short form.
// - coprocessor branches may raise coprocessor-unusable or reserved-instruction exceptions.
// - branch-if-equal compares both source registers fully and branches after the delay slot on a match.
// - branch-if-equal with both sources on the zero register is always taken.
`default_nettype none
`include "ccb_consts.vh"

module ccb_branch_unit #(
  parameter XLEN = 32
) (
  input  wire            core_clk_i,
  input  wire            rst_i,
  input  wire            ce_i,
  // issue port
  input  wire            issue_valid_i,
  input  wire [31:0]     instr_i,
  input  wire [XLEN-1:0] pc_i,
  input  wire [XLEN-1:0] rs_val_i,
  input  wire [XLEN-1:0] rt_val_i,
  input  wire [7:0]      coproc_condition_bit_i,
  input  wire            coprocessor_two_present_i,
  // apb
  input  wire            psel_i,
  input  wire            penable_i,
  input  wire            pwrite_i,
  input  wire [11:0]     paddr_i,
  input  wire [31:0]     pwdata_i,
  output wire [31:0]     prdata_o,
  output wire            pready_o,
  output wire            pslverr_o,
  // results
  output reg             redirect_o,
  output reg  [XLEN-1:0] redirect_pc_o,
  output reg             squash_delay_slot_o,
  output reg             exc_cpu_o,
  output reg             exc_ri_o,
  output reg             branch_busy_o,
  output wire            irq_o
);

  wire            is_coprocessor_two_br;
  wire            is_beq;
  wire            pol_bit;
  wire            nd_bit;
  wire [2:0]      sel_field;
  wire [4:0]      rs_idx;
  wire [4:0]      rt_idx;
  wire [XLEN-1:0] disp;
  wire [31:0]     ctrl;

  // step-I state carried to the delay-slot step
  reg             pend_reg;
  reg             pend_next;
  reg             taken_reg;
  reg             taken_next;
  reg             likely_reg;
  reg             likely_next;
  reg  [XLEN-1:0] target_reg;
  reg  [XLEN-1:0] target_next;
  reg  [31:0]     count_reg;

  // combinational step-I results
  reg             sel_cond;
  reg             cond;
  reg             do_cpu;
  reg             do_ri;
  reg             is_branch;
  reg [`CCB_EV_N-1:0] events;

  // fields and displacement come from the decoder
  ccb_decode #(
    .XLEN(XLEN)
  ) u_dec (
    .instr_i                  (instr_i),
    .is_coprocessor_two_br_o             (is_coprocessor_two_br),
    .is_beq_o                 (is_beq),
    .polarity_bit_o           (pol_bit),
    .nullify_delay_slot_bit_o (nd_bit),
    .condition_select_field_o (sel_field),
    .rs_idx_o                 (rs_idx),
    .rt_idx_o                 (rt_idx),
    .displacement_o           (disp)
  );

  // condition evaluation in the branch step
  always @* begin
    // live read of the selected coprocessor bit
    sel_cond = coproc_condition_bit_i[sel_field];
    // exceptions: unit disabled, or no coprocessor fitted
    do_cpu = issue_valid_i && is_coprocessor_two_br && !ctrl[`CCB_CTRL_CU2];
    do_ri  = issue_valid_i && is_coprocessor_two_br && ctrl[`CCB_CTRL_CU2] &&
             !(coprocessor_two_present_i && ctrl[`CCB_CTRL_PRES]);
    is_branch = issue_valid_i && ((is_coprocessor_two_br && !do_cpu && !do_ri) || is_beq);
    cond = 1'b0;
    if (is_coprocessor_two_br) begin
      // false form wants 0, true form wants 1
      cond = pol_bit ? sel_cond : !sel_cond;
    end else if (is_beq) begin
      // full-width compare; zero-register pair always matches
      cond = (rs_val_i == rt_val_i) ||
             (rs_idx == `CCB_ZERO_REG && rt_idx == `CCB_ZERO_REG);
    end
  end

  // next-state of the pending branch
  always @* begin
    pend_next   = 1'b0;
    taken_next  = taken_reg;
    likely_next = likely_reg;
    target_next = target_reg;
    // a new branch is not accepted in the delay-slot step
    if (is_branch && !pend_reg) begin
      pend_next   = 1'b1;
      taken_next  = cond;
      likely_next = is_coprocessor_two_br && nd_bit;
      // target relative to the delay-slot address
      target_next = pc_i + `CCB_DS_STEP + disp;
    end
  end

  // event sources for the interrupt status
  always @* begin
    events = {`CCB_EV_N{1'b0}};
    events[`CCB_EV_CPU]    = do_cpu;
    events[`CCB_EV_RI]     = do_ri;
    events[`CCB_EV_TAKEN]  = pend_reg && issue_valid_i && taken_reg;
    events[`CCB_EV_SQUASH] = pend_reg && issue_valid_i && likely_reg && !taken_reg;
  end

  // step I records, step I+1 acts; delay slot waits for its issue
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      pend_reg            <= 1'b0;
      taken_reg           <= 1'b0;
      likely_reg          <= 1'b0;
      target_reg          <= {XLEN{1'b0}};
      count_reg           <= 32'h0000_0000;
      redirect_o          <= 1'b0;
      redirect_pc_o       <= {XLEN{1'b0}};
      squash_delay_slot_o <= 1'b0;
      exc_cpu_o           <= 1'b0;
      exc_ri_o            <= 1'b0;
      branch_busy_o       <= 1'b0;
    end else if (ce_i) begin
      exc_cpu_o           <= do_cpu;
      exc_ri_o            <= do_ri;
      redirect_o          <= 1'b0;
      squash_delay_slot_o <= 1'b0;
      if (pend_reg) begin
        // hold until the delay-slot instruction issues
        if (issue_valid_i) begin
          pend_reg            <= 1'b0;
          branch_busy_o       <= 1'b0;
          redirect_o          <= taken_reg;
          redirect_pc_o       <= target_reg;
          squash_delay_slot_o <= likely_reg && !taken_reg;
          if (taken_reg)
            count_reg <= count_reg + 32'h0000_0001;
        end
      end else begin
        pend_reg      <= pend_next;
        taken_reg     <= taken_next;
        likely_reg    <= likely_next;
        target_reg    <= target_next;
        branch_busy_o <= pend_next;
      end
    end
  end

  // register file and interrupt gating
  ccb_apb_regs u_regs (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .psel_i     (psel_i),
    .penable_i  (penable_i),
    .pwrite_i   (pwrite_i),
    .paddr_i    (paddr_i),
    .pwdata_i   (pwdata_i),
    .event_i    (events),
    .status_i   ({29'h0000_0000, likely_reg, taken_reg, pend_reg}),
    .count_i    (count_reg),
    .prdata_o   (prdata_o),
    .pready_o   (pready_o),
    .pslverr_o  (pslverr_o),
    .ctrl_o     (ctrl),
    .irq_o      (irq_o)
  );

endmodule // ccb_branch_unit

`default_nettype wire

// [ccb_branch_unit_assertions.sv]
// checker on the ports of the branch unit
// assumes one clock domain and a synchronous active-high reset
`default_nettype none
`include "ccb_consts.vh"
module ccb_chk #(
  parameter XLEN = 32
) (
  input wire logic            core_clk_i,
  input wire logic            rst_i,
  input wire logic            ce_i,
  input wire logic            issue_valid_i,
  input wire logic [31:0]     instr_i,
  input wire logic [XLEN-1:0] pc_i,
  input wire logic [XLEN-1:0] rs_val_i,
  input wire logic [XLEN-1:0] rt_val_i,
  input wire logic [7:0]      coproc_condition_bit_i,
  input wire logic            redirect_o,
  input wire logic [XLEN-1:0] redirect_pc_o,
  input wire logic            squash_delay_slot_o,
  input wire logic            exc_cpu_o,
  input wire logic            exc_ri_o,
  input wire logic            branch_busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // a branch counts only outside a delay slot
  wire br  = ce_i && issue_valid_i && !branch_busy_o;
  wire cop = instr_i[31:26] == `CCB_OP_COPROCESSOR_TWO && instr_i[25:21] == `CCB_SUB_BC;
  wire branch_if_equal = instr_i[31:26] == `CCB_OP_BEQ;
  wire nd  = instr_i[`CCB_ND_BIT];
  wire hit = cop ? coproc_condition_bit_i[instr_i[20:18]] == instr_i[`CCB_TF_BIT]
                 : rs_val_i == rt_val_i || instr_i[25:16] == 10'h000;
  reg  [XLEN-1:0] tgt_reg;
  reg             cop_reg;
  reg             beq_q;
  // expected target, held until the slot resolves
  always @(posedge core_clk_i) begin
    cop_reg <= !rst_i && br && cop;
    if (br)
      tgt_reg <= pc_i + `CCB_DS_STEP + {{(XLEN-18){instr_i[15]}}, instr_i[15:0], 2'b00};
  end
  a_target_value: assert property (redirect_o |-> redirect_pc_o == tgt_reg)
    else $error("redirect target wrong");
  a_cop_taken: assert property (
    br && cop && hit ##1 issue_valid_i && !exc_cpu_o && !exc_ri_o |=> redirect_o)
    else $error("coproc branch not taken");
  a_cop_untaken: assert property (br && cop && !hit ##1 issue_valid_i |=> !redirect_o)
    else $error("coproc branch wrongly taken");
  a_likely_squash: assert property (
    br && cop && nd && !hit ##1 issue_valid_i && !exc_cpu_o && !exc_ri_o
    |=> squash_delay_slot_o && !redirect_o) else $error("likely slot not squashed");
  a_slot_kept: assert property (
    br && (branch_if_equal || cop && (hit || !nd)) ##1 issue_valid_i |=> !squash_delay_slot_o)
    else $error("delay slot squashed wrongly");
  a_beq_equal: assert property (br && branch_if_equal && hit ##1 issue_valid_i |=> redirect_o)
    else $error("equal operands not taken");
  a_beq_differ: assert property (br && branch_if_equal && !hit ##1 issue_valid_i |=> !redirect_o)
    else $error("unequal operands taken");
  a_slot_first: assert property (
    br && (cop || branch_if_equal) |=> !redirect_o && !squash_delay_slot_o)
    else $error("redirect before delay slot");
  a_exc_cause: assert property ((exc_cpu_o || exc_ri_o) |-> cop_reg && !beq_q)
    else $error("exception without coproc branch");
  // equality branches never fault
  always @(posedge core_clk_i) beq_q <= br && branch_if_equal;
endmodule // ccb_chk
bind ccb_branch_unit ccb_chk #(.XLEN(XLEN)) u_chk (.*);
`default_nettype wire

// [ccb_coprocessor_two_model.sv]
// coprocessor two stand-in: condition vector and presence
// assumes the bench sets flags one cycle before a branch issues
`default_nettype none
module ccb_coprocessor_two_model (
  input  wire logic       core_clk_i,
  input  wire logic [7:0] flags_i,
  input  wire logic       fitted_i,
  output var  logic [7:0] coproc_condition_bit_o,
  output var  logic       coprocessor_two_present_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // bit n answers select value n, registered on the core clock
  always @(posedge core_clk_i) begin
    coproc_condition_bit_o <= flags_i;
    coprocessor_two_present_o <= fitted_i;
  end
endmodule // ccb_coprocessor_two_model
`default_nettype wire

// [ccb_branch_unit_bench.sv]
// self-checking bench for the branch unit with an apb master
// assumes the coprocessor model file and the bound checker
`default_nettype none
`include "ccb_consts.vh"
module ccb_branch_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, vld = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, fit = 1'b1;
  logic [31:0] instr = '0, pc = '0, rsv = '0, rtv = '0, pwdata = '0, rpc, prdata, q;
  logic [11:0] paddr = '0;
  logic [7:0]  flags = '0, cond;
  logic        ce = 1'b1;
  logic        pready, perr, redir, squash, exc_cpu, exc_ri, busy, irq, present, e;
  int          n_errors = 0, comparisons = 0, taken_n = 0, k;
  always #2 clk = ~clk;
  // clock enable runs high except in the freeze test
  ccb_branch_unit DUT (.core_clk_i(clk), .rst_i(rst), .ce_i(ce), .issue_valid_i(vld),
    .instr_i(instr), .pc_i(pc), .rs_val_i(rsv), .rt_val_i(rtv), .coproc_condition_bit_i(cond),
    .coprocessor_two_present_i(present), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .redirect_o(redir), .redirect_pc_o(rpc), .squash_delay_slot_o(squash),
    .exc_cpu_o(exc_cpu), .exc_ri_o(exc_ri), .branch_busy_o(busy), .irq_o(irq));
  ccb_coprocessor_two_model u_cop (.core_clk_i(clk), .flags_i(flags), .fitted_i(fit),
    .coproc_condition_bit_o(cond), .coprocessor_two_present_o(present));
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      print_verdict;
    end
    q = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    apb(1'b0, a, 32'h0000_0000);
    check({31'h0, e}, {31'h0, experr}, "apb error flag");
    check(q, exp, "apb read data");
  endtask
  // branch then a plain delay slot; exp is {redirect, squash, cpu fault, ri fault}
  task automatic br(input logic [31:0] ins, input logic [7:0] f, input logic [31:0] a,
                    input logic [31:0] b, input logic [3:0] exp);
    logic [31:0] tgt;
    tgt = 32'h0001_0004 + {{14{ins[15]}}, ins[15:0], 2'b00};
    @(posedge clk);
    flags <= f;
    rsv <= a;
    rtv <= b;
    @(posedge clk);
    vld <= 1'b1;
    instr <= ins;
    pc <= 32'h0001_0000;
    @(posedge clk);
    instr <= 32'h0000_0000;
    pc <= 32'h0001_0004;
    #1 check({exc_cpu, exc_ri, redir}, {exp[1:0], 1'b0}, "faults");
    @(posedge clk);
    vld <= 1'b0;
    #1 check({redir, squash}, exp[3:2], "resolve");
    if (exp[3]) check(rpc, tgt, "target");
    if (exp[3]) taken_n++;
  endtask
  function automatic logic [31:0] cop(input logic [2:0] s, input logic n, t, input logic [15:0] o);
    return {`CCB_OP_COPROCESSOR_TWO, `CCB_SUB_BC, s, n, t, o};
  endfunction
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 check({redir, squash, exc_cpu, exc_ri, irq}, 32'h0000_0000, "reset outputs");
    rd(`CCB_REG_CTRL, `CCB_CTRL_RESET, 1'b0);
    rd(12'h100, 32'h0000_0000, 1'b1);
    $display("test reset finished");
    br(cop(3'h0, 1'b0, 1'b1, 16'h0010), 8'h01, 0, 0, 4'b0010);
    apb(1'b1, `CCB_REG_CTRL, 32'h0000_0001);
    br(cop(3'h0, 1'b0, 1'b1, 16'h0010), 8'h01, 0, 0, 4'b0001);
    apb(1'b1, `CCB_REG_CTRL, 32'h0000_0003);
    // frozen core: a branch issued while ce is low leaves no trace
    @(posedge clk);
    ce <= 1'b0;
    vld <= 1'b1;
    instr <= cop(3'h0, 1'b0, 1'b0, 16'h0001);
    repeat (3) @(posedge clk);
    #1 check({busy, redir, squash, exc_cpu, exc_ri}, 32'h0000_0000, "frozen outputs");
    @(posedge clk);
    ce <= 1'b1;
    vld <= 1'b0;
    $display("test faults finished");
    // every polarity and likely form, each select value, both offset extremes
    for (k = 0; k < 8; k++)
      br(cop(k[2:0], k[0], k[1], k[2] ? 16'h8000 : 16'h7FFF), 8'h96, 0, 0,
         {((8'h96 >> k) & 1) == k[1], k[0] && ((8'h96 >> k) & 1) != k[1], 2'b00});
    $display("test coproc finished");
    br({`CCB_OP_BEQ, 10'h0C6, 16'hFFFF}, 0, 32'h8000_0001, 32'h8000_0001, 4'b1000);
    br({`CCB_OP_BEQ, 10'h0C6, 16'h0004}, 0, 32'h8000_0001, 32'h0000_0001, 4'b0000);
    br({`CCB_OP_BEQ, 10'h000, 16'h0100}, 0, 32'h0000_0005, 32'h0000_0007, 4'b1000);
    $display("test equal finished");
    rd(`CCB_REG_IRQ_ST, 32'h0000_000F, 1'b0);
    check({31'h0, irq}, 32'h0000_0000, "irq masked");
    apb(1'b1, `CCB_REG_IRQ_EN, 32'h0000_0004);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0000_0001, "irq raised");
    apb(1'b1, `CCB_REG_IRQ_CLR, 32'h0000_000F);
    rd(`CCB_REG_IRQ_ST, 32'h0000_0000, 1'b0);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0000_0000, "irq cleared");
    rd(`CCB_REG_CNT, taken_n, 1'b0);
    $display("test interrupt finished");
    print_verdict;
  end
endmodule // ccb_branch_unit_bench
`default_nettype wire
